/* src/toolkit_pkg.sv */
package toolkit_pkg;

  // ==========================================================================
  // Status words and procedure bytes
  // ==========================================================================
  localparam logic [7:0] NULL_PROC_BYTE = 8'h60;
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_ACK_READY = 16'h9F10;
  localparam logic [7:0] SW1_PENDING = 8'h91;
  localparam logic [15:0] SW_BUSY = 16'h9300;
  localparam logic [7:0] ACK_LEN = 8'h10;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 5;
  localparam int NULL_GAP_NS = 1000;
  localparam logic [15:0] NULL_GAP_CYC = 16'(NULL_GAP_NS / CLK_PERIOD_NS);
  localparam logic [3:0] NULL_MAX = 4'h8;

  // ==========================================================================
  // Command codes presented on the command port
  // ==========================================================================
  typedef enum logic [2:0] {
    CMD_ENVELOPE = 3'h0,
    CMD_GET_RESPONSE = 3'h1,
    CMD_FETCH = 3'h2,
    CMD_TERM_RESP = 3'h3,
    CMD_ORDINARY = 3'h4
  } cmd_t;

  // Application outcome codes.
  typedef enum logic [1:0] {
    RES_DONE = 2'h0,
    RES_ACK = 2'h1,
    RES_COMMAND = 2'h2,
    RES_MORE_TIME = 2'h3
  } result_t;

endpackage

/* src/app_link_if.sv */
`timescale 1ns/1ps
interface app_link_if;
  logic start;
  logic busy;
  logic done;
  logic [1:0] result;
  logic [7:0] cmd_len;
  modport engine (output start, input busy, input done, input result, input cmd_len);
  modport app (input start, output busy, output done, output result, output cmd_len);
endinterface

/* src/null_pacer.sv */
`timescale 1ns/1ps
module null_pacer
  import toolkit_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic tick_o,
  output logic exhausted_o
);

  logic [15:0] gap;
  logic [3:0] sent;
  logic [15:0] next_gap;
  logic [3:0] next_sent;

  // The count of null bytes is capped so the terminal regains the line soon.
  always_comb begin
    next_gap = gap;
    next_sent = sent;
    tick_o = 1'b0;
    if (!run_i) begin
      next_gap = 16'h0000;
      next_sent = 4'h0;
    end else if (gap == NULL_GAP_CYC - 16'h0001) begin
      next_gap = 16'h0000;
      if (sent != NULL_MAX) begin
        tick_o = 1'b1;
        next_sent = sent + 4'h1;
      end
    end else begin
      next_gap = gap + 16'h0001;
    end
  end

  assign exhausted_o = (sent == NULL_MAX);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap <= 16'h0000;
      sent <= 4'h0;
    end else begin
      gap <= next_gap;
      sent <= next_sent;
    end
  end

endmodule

/* src/card_toolkit_status_exchange.sv */
`timescale 1ns/1ps
module card_toolkit_status_exchange
  import toolkit_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_code_i,
  output logic cmd_ready_o,
  output logic proc_valid_o,
  output logic [7:0] proc_byte_o,
  output logic sw_valid_o,
  output logic [15:0] sw_o,
  output logic app_start_o,
  input wire logic app_busy_i,
  input wire logic app_done_i,
  input wire logic [1:0] app_result_i,
  input wire logic [7:0] app_cmd_len_i
);

  // ==========================================================================
  // Application link
  // ==========================================================================
  app_link_if link ();
  assign app_start_o = link.start;
  assign link.busy = app_busy_i;
  assign link.done = app_done_i;
  assign link.result = app_result_i;
  assign link.cmd_len = app_cmd_len_i;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PROC = 3'b010,
    ST_ANSWER = 3'b100
  } state_t;

  state_t state;
  state_t next_state;
  logic pending;
  logic next_pending;
  logic ack_ready;
  logic next_ack_ready;
  logic [7:0] pend_len;
  logic [7:0] next_pend_len;
  logic more_time;
  logic next_more_time;
  logic [15:0] sw;
  logic [15:0] next_sw;
  logic sw_valid;
  logic next_sw_valid;
  logic proc_valid;
  logic next_proc_valid;
  logic start;
  logic next_start;
  logic tick;
  logic exhausted;
  logic [15:0] idle_sw;
  logic app_fin;
  logic next_app_fin;
  logic [1:0] app_res;
  logic [1:0] next_app_res;
  logic [7:0] app_len;
  logic [7:0] next_app_len;

  null_pacer pacer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(state == ST_PROC),
    .tick_o(tick),
    .exhausted_o(exhausted)
  );

  assign link.start = start;
  assign cmd_ready_o = (state == ST_IDLE);
  assign proc_valid_o = proc_valid;
  assign proc_byte_o = NULL_PROC_BYTE;
  assign sw_valid_o = sw_valid;
  assign sw_o = sw;

  // A reminder status keeps nagging the terminal while a command waits.
  assign idle_sw = pending ? {SW1_PENDING, pend_len} : SW_OK;

  // ==========================================================================
  // Command sequencing
  // ==========================================================================
  always_comb begin
    next_state = state;
    next_pending = pending;
    next_ack_ready = ack_ready;
    next_pend_len = pend_len;
    next_more_time = more_time;
    next_sw = sw;
    next_sw_valid = 1'b0;
    next_proc_valid = 1'b0;
    next_start = 1'b0;
    next_app_fin = app_fin;
    next_app_res = app_res;
    next_app_len = app_len;
    unique case (state)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          next_sw_valid = 1'b1;
          next_sw = idle_sw;
          case (cmd_code_i)
            CMD_ENVELOPE: begin
              if (link.busy || more_time) begin
                next_sw = SW_BUSY;
              end else begin
                next_sw_valid = 1'b0;
                next_start = 1'b1;
                next_ack_ready = 1'b0;
                next_state = ST_PROC;
              end
            end
            CMD_GET_RESPONSE: begin
              if (ack_ready) begin
                next_ack_ready = 1'b0;
                next_pend_len = ACK_LEN;
                next_sw = SW_OK;
              end
            end
            CMD_FETCH: begin
              if (pending) begin
                next_pending = 1'b0;
                next_sw = SW_OK;
                if (more_time) begin
                  // The application resumes its work after the terminal got MORE TIME.
                  next_sw_valid = 1'b0;
                  next_more_time = 1'b0;
                  next_state = ST_PROC;
                end
              end
            end
            CMD_TERM_RESP: begin
              next_sw = idle_sw;
            end
            default: begin
              next_sw = idle_sw;
            end
          endcase
        end
      end
      ST_PROC: begin
        if (link.done || app_fin) begin
          next_state = ST_ANSWER;
        end else if (exhausted) begin
          // Out of null bytes: hand the line back through a MORE TIME round.
          next_pending = 1'b1;
          next_more_time = 1'b1;
          next_pend_len = ACK_LEN;
          next_sw_valid = 1'b1;
          next_sw = {SW1_PENDING, ACK_LEN};
          next_state = ST_IDLE;
        end else begin
          next_proc_valid = tick;
        end
      end
      ST_ANSWER: begin
        next_sw_valid = 1'b1;
        next_state = ST_IDLE;
        next_app_fin = 1'b0;
        unique case (app_res)
          RES_DONE: next_sw = SW_OK;
          RES_ACK: begin
            next_ack_ready = 1'b1;
            next_sw = SW_ACK_READY;
          end
          RES_COMMAND: begin
            next_pending = 1'b1;
            next_pend_len = app_len;
            next_sw = {SW1_PENDING, app_len};
          end
          RES_MORE_TIME: begin
            next_pending = 1'b1;
            next_more_time = 1'b1;
            next_pend_len = app_len;
            next_sw = {SW1_PENDING, app_len};
          end
        endcase
      end
      default: next_state = ST_IDLE;
    endcase
    // The outcome is only valid with the done pulse, so it is kept until the answer goes out.
    // A pulse that lands while the card waits for FETCH in a MORE TIME round is not lost.
    if (link.done) begin
      next_app_fin = 1'b1;
      next_app_res = link.result;
      next_app_len = link.cmd_len;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      pending <= 1'b0;
      ack_ready <= 1'b0;
      pend_len <= 8'h00;
      more_time <= 1'b0;
      sw <= 16'h0000;
      sw_valid <= 1'b0;
      proc_valid <= 1'b0;
      start <= 1'b0;
      app_fin <= 1'b0;
      app_res <= 2'h0;
      app_len <= 8'h00;
    end else begin
      state <= next_state;
      pending <= next_pending;
      ack_ready <= next_ack_ready;
      pend_len <= next_pend_len;
      more_time <= next_more_time;
      sw <= next_sw;
      sw_valid <= next_sw_valid;
      proc_valid <= next_proc_valid;
      start <= next_start;
      app_fin <= next_app_fin;
      app_res <= next_app_res;
      app_len <= next_app_len;
    end
  end

endmodule

/* sim/card_toolkit_status_exchange_chk.sv */
`timescale 1ns/1ps
module card_toolkit_status_exchange_chk
  import toolkit_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_code_i,
  input wire logic cmd_ready_o,
  input wire logic proc_valid_o,
  input wire logic [7:0] proc_byte_o,
  input wire logic sw_valid_o,
  input wire logic [15:0] sw_o,
  input wire logic app_start_o,
  input wire logic app_busy_i,
  input wire logic app_done_i,
  input wire logic [1:0] app_result_i,
  input wire logic [7:0] app_cmd_len_i
);
  // A pending command stays owed from a 91XX status until the terminal fetches it.
  logic pend;
  wire logic take = cmd_valid_i && cmd_ready_o;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pend <= 1'b0;
    else if (sw_valid_o && sw_o[15:8] == SW1_PENDING) pend <= 1'b1;
    else if (take && cmd_code_i == CMD_FETCH) pend <= 1'b0;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_BYTE: assert property (proc_valid_o |-> proc_byte_o == NULL_PROC_BYTE) else $error("bad null byte");
  AST_QUIET: assert property (proc_valid_o |-> !cmd_ready_o) else $error("ready during null");
  AST_START: assert property (take && cmd_code_i == CMD_ENVELOPE && !app_busy_i && !pend
    |=> app_start_o && !cmd_ready_o) else $error("no start");
  AST_ACK: assert property (app_done_i && app_result_i == RES_ACK
    |-> ##2 sw_valid_o && sw_o == SW_ACK_READY) else $error("bad ack status");
  AST_PEND: assert property (app_done_i && app_result_i == RES_COMMAND
    |-> ##2 sw_valid_o && sw_o == {SW1_PENDING, $past(app_cmd_len_i, 2)}) else $error("bad pending");
  AST_TRESP: assert property (take && cmd_code_i == CMD_TERM_RESP && !pend
    |=> sw_valid_o && sw_o == SW_OK) else $error("bad response status");
  AST_REMIND: assert property (take && cmd_code_i == CMD_ORDINARY && pend
    |=> sw_valid_o && sw_o[15:8] == SW1_PENDING) else $error("no reminder");
  AST_BUSY: assert property (take && cmd_code_i == CMD_ENVELOPE && app_busy_i
    |=> sw_valid_o && sw_o == SW_BUSY) else $error("no busy status");
endmodule
bind card_toolkit_status_exchange card_toolkit_status_exchange_chk chk (.*);

/* sim/app_model.sv */
`timescale 1ns/1ps
module app_model
  import toolkit_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic hog_i,
  input wire logic [15:0] lat_i,
  input wire logic [1:0] res_i,
  output logic busy_o,
  output logic done_o,
  output logic [1:0] result_o,
  output logic [7:0] cmd_len_o
);
  logic run;
  logic [15:0] rem;
  logic [7:0] fr;
  assign busy_o = run | hog_i;
  // Outside the done pulse the outputs churn, so a late sample shows up.
  assign result_o = done_o ? res_i : fr[1:0];
  assign cmd_len_o = done_o ? 8'h2A : ~fr;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run <= 1'b0;
      rem <= 16'h0000;
      done_o <= 1'b0;
      fr <= 8'h00;
    end else begin
      fr <= fr + 8'h01;
      done_o <= run && rem == 16'h0001;
      if (start_i && !busy_o) begin
        run <= 1'b1;
        rem <= lat_i;
      end else if (done_o && res_i == RES_MORE_TIME) begin
        // The application keeps working after it asked for more time.
        run <= 1'b1;
        rem <= lat_i;
      end else if (run) begin
        rem <= rem - 16'h0001;
        run <= rem != 16'h0001;
      end
    end
  end
endmodule

/* sim/tb_card_toolkit_status_exchange.sv */
`timescale 1ns/1ps
module tb_card_toolkit_status_exchange;
  import toolkit_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [2:0] cmd_code_i = 3'h0;
  logic hog = 1'b0;
  logic [15:0] lat = 16'h0000;
  logic [1:0] res = 2'h0;
  logic cmd_ready_o, proc_valid_o, sw_valid_o, app_start_o, app_busy_i, app_done_i;
  logic [7:0] proc_byte_o, app_cmd_len_i;
  logic [15:0] sw_o;
  logic [1:0] app_result_i;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int nulls;
  always #2.5 core_clk_i = ~core_clk_i;
  card_toolkit_status_exchange uut (.*);
  app_model pm (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_i(app_start_o), .hog_i(hog), .lat_i(lat),
    .res_i(res), .busy_o(app_busy_i), .done_o(app_done_i), .result_o(app_result_i), .cmd_len_o(app_cmd_len_i));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // A missing status compares as unknown, so a stale sw_o never passes.
  task automatic xfer(input logic [2:0] c, input logic [15:0] exp, input int lim);
    int n;
    n = 0;
    nulls = 0;
    // One edge always passes first, so the strobe is never lowered and raised in one time step.
    do begin
      @(posedge core_clk_i) #1;
    end while (cmd_ready_o !== 1'b1);
    cmd_valid_i = 1'b1;
    cmd_code_i = c;
    @(posedge core_clk_i) #1;
    cmd_valid_i = 1'b0;
    while (sw_valid_o !== 1'b1 && n < lim) begin
      if (proc_valid_o === 1'b1) nulls++;
      @(posedge core_clk_i) #1;
      n++;
    end
    chk(sw_valid_o ? sw_o : 16'hXXXX, exp);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_ack();
    lat = 16'h02BC;
    res = RES_ACK;
    xfer(CMD_ENVELOPE, SW_ACK_READY, 2000);
    chk(16'(nulls != 0), 16'h0001);
    xfer(CMD_GET_RESPONSE, SW_OK, 4);
    $display("test ack done");
  endtask
  task automatic t_cmd();
    lat = 16'h000A;
    res = RES_COMMAND;
    xfer(CMD_ENVELOPE, {SW1_PENDING, 8'h2A}, 100);
    xfer(CMD_ORDINARY, {SW1_PENDING, 8'h2A}, 4);
    xfer(CMD_FETCH, SW_OK, 4);
    xfer(CMD_TERM_RESP, SW_OK, 4);
    $display("test command done");
  endtask
  task automatic t_busy();
    hog = 1'b1;
    xfer(CMD_ENVELOPE, SW_BUSY, 4);
    hog = 1'b0;
    $display("test busy done");
  endtask
  task automatic t_simple();
    lat = 16'h0002;
    res = RES_DONE;
    xfer(CMD_ENVELOPE, SW_OK, 100);
    chk(16'(nulls), 16'h0000);
    $display("test simple done");
  endtask
  task automatic t_mt();
    lat = 16'h0014;
    res = RES_MORE_TIME;
    xfer(CMD_ENVELOPE, {SW1_PENDING, 8'h2A}, 100);
    res = RES_DONE;
    xfer(CMD_ORDINARY, {SW1_PENDING, 8'h2A}, 4);
    xfer(CMD_FETCH, SW_OK, 100);
    $display("test app more time done");
  endtask
  task automatic t_long();
    lat = 16'h0A28;
    res = RES_DONE;
    xfer(CMD_ENVELOPE, {SW1_PENDING, 8'h10}, 2000);
    chk(16'(nulls), 16'(NULL_MAX));
    xfer(CMD_ORDINARY, {SW1_PENDING, 8'h10}, 4);
    xfer(CMD_FETCH, SW_OK, 2000);
    $display("test more time done");
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    t_ack();
    t_cmd();
    t_busy();
    t_long();
    t_simple();
    t_mt();
    end_of_test();
  end
endmodule
